// File: nvc_controller.sv
// Operation
// - Command field write issues one of seven commands (code 0 is no-op)
// - Address register selects flash or eeprom target
// - Fuse write starts only from debug port
// - Chip erase spares eeprom when keep fuse set
// - Boot read lock blocks boot section reads
// - Boot lock written from boot only, sticky
// - Boot lock acts after first boot exit
// - App write protect set-only, cleared by reset
// - Write fault shows error of last operation
// - Eeprom busy bit mirrors eeprom activity
// - Flash busy bit mirrors flash activity
// - Ready interrupt enable turns on level interrupt
// - Ready flag set while eeprom idle, W1C
// - Data and address are 16-bit byte pairs
// - Data register feeds fuse write value
// - Address register tracks last updated location
// - Unprotected command write leaves register unchanged
// - Buffer clear halts CPU seven cycles
// - Interrupt active while enabled and flag set
module nvc_controller
  import nvc_pkg::*;
#(
  parameter logic [15:0] EEPROM_BASE = 16'h1400,
  parameter logic [15:0] EEPROM_TOP  = 16'h14FF,
  parameter logic [15:0] APP_BASE    = 16'h8000
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    hsel,
  input  wire logic [ADDR_W-1:0]       haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic [31:0]                  hrdata,
  output logic                         hresp,
  input  wire logic                    dbg_master,
  input  wire logic                    prot_key_open,
  input  wire logic                    exec_in_boot,
  input  wire logic                    keep_eeprom_on_erase,
  input  wire logic                    flash_busy_in,
  input  wire logic                    eeprom_busy_in,
  input  wire logic                    write_fault_in,
  input  wire logic                    loc_update,
  input  wire logic [15:0]             loc_update_addr,
  output nvc_pkg::nvc_op_s             op_req,
  output logic                         op_start,
  output logic                         cpu_halt,
  output logic                         boot_read_lock,
  output logic                         app_write_protect,
  output logic                         irq
);

  // ----------------------------------------------------------------
  // Bus slave: one wait state so writes land before any later read
  // ----------------------------------------------------------------
  nvc_bus_e         state;
  nvc_bus_e         next_state;
  logic [IDX_W-1:0] lat_idx;
  logic             lat_write;
  logic             lat_hit;
  logic             lat_dbg;

  wire              addr_ok  = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire              in_range = (haddr[ADDR_W-1:IDX_LSB+IDX_W] == '0)
                               & (haddr[IDX_LSB+IDX_W-1:IDX_LSB] <= IDX_LAST);
  wire              pend     = (state == NVC_BUS_PEND);
  wire              wr_commit = pend & lat_write & lat_hit;
  wire              rd_commit = pend & ~lat_write;
  wire [7:0]        wr_byte  = hwdata[7:0];

  assign next_state = addr_ok ? NVC_BUS_PEND : NVC_BUS_IDLE;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state     <= NVC_BUS_IDLE;
      lat_idx   <= '0;
      lat_write <= 1'b0;
      lat_hit   <= 1'b0;
      lat_dbg   <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      state     <= next_state;
      hreadyout <= ~addr_ok;
      hresp     <= HRESP_OKAY;
      if (addr_ok) begin
        lat_idx   <= haddr[IDX_LSB+IDX_W-1:IDX_LSB];
        lat_write <= hwrite;
        lat_hit   <= in_range;
        lat_dbg   <= dbg_master;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [CMD_W-1:0] nvm_command;
  logic             boot_pending;
  logic             in_boot_q;
  logic             st_flash_busy;
  logic             st_eeprom_busy;
  logic             st_write_fault;
  logic             irq_enable;
  logic             ready_flag;
  logic [15:0]      fuse_write_value;
  logic [15:0]      nvm_location;
  logic [2:0]       clr_cnt;

  wire sel_cmd   = wr_commit & (lat_idx == IDX_CMD);
  wire sel_lock  = wr_commit & (lat_idx == IDX_LOCK);
  wire sel_ien   = wr_commit & (lat_idx == IDX_IRQ_EN);
  wire sel_flag  = wr_commit & (lat_idx == IDX_FLAGS);
  wire sel_d_lo  = wr_commit & (lat_idx == IDX_DATA_LO);
  wire sel_d_hi  = wr_commit & (lat_idx == IDX_DATA_HI);
  wire sel_l_lo  = wr_commit & (lat_idx == IDX_LOC_LO);
  wire sel_l_hi  = wr_commit & (lat_idx == IDX_LOC_HI);

  // Key window is tracked by the CPU side; debug port is exempt
  wire cmd_unlocked = prot_key_open | lat_dbg;
  wire wr_cmd       = sel_cmd & cmd_unlocked;
  wire [CMD_W-1:0] new_code = wr_byte[CMD_W-1:0];

  wire target_eeprom = (nvm_location >= EEPROM_BASE)
                       & (nvm_location <= EEPROM_TOP);
  wire page_cmd   = (new_code == CMD_PAGE_WRITE) | (new_code == CMD_PAGE_ERASE)
                    | (new_code == CMD_ERASE_WR);
  wire fuse_refused = (new_code == CMD_FUSE_WRITE) & ~lat_dbg;
  wire prot_hit   = page_cmd & ~target_eeprom & app_write_protect
                    & (nvm_location >= APP_BASE);
  wire busy_any   = flash_busy_in | eeprom_busy_in | (clr_cnt != 3'h0);
  // Commands arriving while busy are dropped rather than queued
  wire start_ok   = wr_cmd & (new_code != CMD_NOP) & ~fuse_refused
                    & ~prot_hit & ~busy_any;
  wire fault_set  = (wr_cmd & prot_hit) | write_fault_in;

  wire [2:0] next_clr_cnt = (start_ok & (new_code == CMD_BUF_CLEAR)) ? BUF_CLEAR_CYCLES
                            : (clr_cnt != 3'h0) ? clr_cnt - 3'h1 : 3'h0;
  wire flag_clear  = sel_flag & wr_byte[BIT_EEPROM_READY];
  wire next_flag   = ~eeprom_busy_in | (ready_flag & ~flag_clear);
  wire boot_exit   = in_boot_q & ~exec_in_boot;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nvm_command <= CMD_NOP;
    end else if (wr_cmd) begin
      nvm_command <= new_code;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      app_write_protect <= 1'b0;
      boot_pending      <= 1'b0;
      boot_read_lock    <= 1'b0;
      in_boot_q         <= 1'b0;
    end else begin
      in_boot_q <= exec_in_boot;
      if (sel_lock & wr_byte[BIT_APP_WP]) begin
        app_write_protect <= 1'b1;
      end
      if (sel_lock & wr_byte[BIT_BOOT_LOCK] & exec_in_boot) begin
        boot_pending <= 1'b1;
      end
      if (boot_pending & boot_exit) begin
        boot_read_lock <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_flash_busy  <= 1'b0;
      st_eeprom_busy <= 1'b0;
      st_write_fault <= 1'b0;
    end else begin
      st_flash_busy  <= flash_busy_in;
      st_eeprom_busy <= eeprom_busy_in;
      st_write_fault <= fault_set | (st_write_fault & ~start_ok);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable <= 1'b0;
      ready_flag <= 1'b0;
      irq        <= 1'b0;
    end else begin
      if (sel_ien) begin
        irq_enable <= wr_byte[BIT_EEPROM_READY];
      end
      ready_flag <= next_flag;
      irq        <= irq_enable & ready_flag;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fuse_write_value <= RST_WORD;
      nvm_location     <= RST_WORD;
    end else begin
      if (sel_d_lo) fuse_write_value[7:0]  <= wr_byte;
      if (sel_d_hi) fuse_write_value[15:8] <= wr_byte;
      // Hardware update of the location outranks a same-cycle bus write
      if (loc_update) begin
        nvm_location <= loc_update_addr;
      end else begin
        if (sel_l_lo) nvm_location[7:0]  <= wr_byte;
        if (sel_l_hi) nvm_location[15:8] <= wr_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Operation launch towards the memory array
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      op_start <= 1'b0;
      op_req   <= '0;
      clr_cnt  <= 3'h0;
      cpu_halt <= 1'b0;
    end else begin
      op_start <= start_ok;
      clr_cnt  <= next_clr_cnt;
      cpu_halt <= (next_clr_cnt != 3'h0) | flash_busy_in;
      if (start_ok) begin
        op_req.code         <= new_code;
        op_req.tgt_eeprom   <= target_eeprom | (new_code == CMD_EE_ERASE);
        op_req.erase_eeprom <= ((new_code == CMD_CHIP_ERASE) & ~keep_eeprom_on_erase)
                               | (new_code == CMD_EE_ERASE);
        op_req.addr         <= nvm_location;
        op_req.data         <= fuse_write_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] rd_lock  = {6'h00, boot_pending | boot_read_lock, app_write_protect};
  wire [7:0] rd_state = {5'h00, st_write_fault, st_eeprom_busy, st_flash_busy};
  wire [7:0] rd_byte  =
      (lat_idx == IDX_CMD)     ? {5'h00, nvm_command} :
      (lat_idx == IDX_LOCK)    ? rd_lock :
      (lat_idx == IDX_STATE)   ? rd_state :
      (lat_idx == IDX_IRQ_EN)  ? {7'h00, irq_enable} :
      (lat_idx == IDX_FLAGS)   ? {7'h00, ready_flag} :
      (lat_idx == IDX_DATA_LO) ? fuse_write_value[7:0] :
      (lat_idx == IDX_DATA_HI) ? fuse_write_value[15:8] :
      (lat_idx == IDX_LOC_LO)  ? nvm_location[7:0] :
      (lat_idx == IDX_LOC_HI)  ? nvm_location[15:8] : RST_BYTE;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= '0;
    end else if (rd_commit) begin
      hrdata <= {PAD_ZERO, lat_hit ? rd_byte : RST_BYTE};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_cmd_issue: assert property (start_ok |=> op_start && op_req.code == $past(new_code))
    else $error("Accepted command not launched");
  a_cmd_guard: assert property (sel_cmd && !cmd_unlocked |=> $stable(nvm_command))
    else $error("Command register changed without key");
  a_fuse_block: assert property (wr_cmd && new_code == CMD_FUSE_WRITE && !lat_dbg
                                 |=> !op_start)
    else $error("CPU started a fuse write");
  a_target_pick: assert property (start_ok && page_cmd |=> op_req.tgt_eeprom ==
                                  $past(target_eeprom))
    else $error("Wrong memory targeted");
  a_chip_keep: assert property (start_ok && new_code == CMD_CHIP_ERASE
                                |=> op_req.erase_eeprom == !$past(keep_eeprom_on_erase))
    else $error("Chip erase eeprom choice wrong");
  a_boot_defer: assert property ($rose(boot_read_lock) |-> $past(in_boot_q)
                                 && !$past(exec_in_boot))
    else $error("Boot lock active without boot exit");
  a_lock_sticky: assert property (boot_read_lock && app_write_protect
                                  |=> boot_read_lock && app_write_protect)
    else $error("Lock bit cleared without reset");
  a_wp_sticky: assert property (app_write_protect |=> app_write_protect)
    else $error("Write protect cleared without reset");
  a_fault_set: assert property (write_fault_in |=> st_write_fault)
    else $error("Write fault not recorded");
  a_busy_mirror: assert property (flash_busy_in && eeprom_busy_in
                                  |=> st_flash_busy && st_eeprom_busy)
    else $error("Busy status not following array");
  a_ready_flag: assert property (!eeprom_busy_in |=> ready_flag)
    else $error("Ready flag lost while eeprom idle");
  a_irq_level: assert property ((irq_enable && !eeprom_busy_in) [*2] |=> irq)
    else $error("Interrupt not raised");
  a_irq_quiet: assert property ((!irq_enable) [*2] |-> !irq)
    else $error("Interrupt raised while disabled");
  a_clear_halt: assert property (start_ok && new_code == CMD_BUF_CLEAR
                                 |=> cpu_halt [*7] ##1 (!cpu_halt || $past(flash_busy_in)))
    else $error("Buffer clear halt length wrong");
  a_loc_track: assert property (loc_update |=> nvm_location == $past(loc_update_addr))
    else $error("Location not updated");
  a_rsvd_zero: assert property (rd_commit && lat_idx == IDX_STATE
                                |=> hrdata[31:3] == '0)
    else $error("Undefined bits read nonzero");

  c_buf_clear: cover property (op_start && op_req.code == CMD_BUF_CLEAR);
  c_fuse_write: cover property (op_start && op_req.code == CMD_FUSE_WRITE);
  c_boot_lock: cover property ($rose(boot_read_lock));
  c_irq_rise: cover property ($rose(irq));

endmodule

// File: nvc_pkg.sv
package nvc_pkg;

  // ----------------------------------------------------------------
  // Register map: index per register, byte address is index * 4
  // ----------------------------------------------------------------
  localparam int         IDX_W       = 4;
  localparam int         IDX_LSB     = 2;
  localparam int         ADDR_W      = 32;
  localparam logic [3:0] IDX_CMD     = 4'h0;
  localparam logic [3:0] IDX_LOCK    = 4'h1;
  localparam logic [3:0] IDX_STATE   = 4'h2;
  localparam logic [3:0] IDX_IRQ_EN  = 4'h3;
  localparam logic [3:0] IDX_FLAGS   = 4'h4;
  localparam logic [3:0] IDX_DATA_LO = 4'h6;
  localparam logic [3:0] IDX_DATA_HI = 4'h7;
  localparam logic [3:0] IDX_LOC_LO  = 4'h8;
  localparam logic [3:0] IDX_LOC_HI  = 4'h9;
  localparam logic [3:0] IDX_LAST    = 4'h9;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CMD_W            = 3;
  localparam int          BIT_APP_WP       = 0;
  localparam int          BIT_BOOT_LOCK    = 1;
  localparam int          BIT_FLASH_BUSY   = 0;
  localparam int          BIT_EEPROM_BUSY  = 1;
  localparam int          BIT_WRITE_FAULT  = 2;
  localparam int          BIT_EEPROM_READY = 0;
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [15:0] RST_WORD         = 16'h0000;
  localparam logic [23:0] PAD_ZERO         = 24'h00_0000;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_NOP        = 3'h0;
  localparam logic [2:0] CMD_PAGE_WRITE = 3'h1;
  localparam logic [2:0] CMD_PAGE_ERASE = 3'h2;
  localparam logic [2:0] CMD_ERASE_WR   = 3'h3;
  localparam logic [2:0] CMD_BUF_CLEAR  = 3'h4;
  localparam logic [2:0] CMD_CHIP_ERASE = 3'h5;
  localparam logic [2:0] CMD_EE_ERASE   = 3'h6;
  localparam logic [2:0] CMD_FUSE_WRITE = 3'h7;

  // ----------------------------------------------------------------
  // Timing and bus encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] BUF_CLEAR_CYCLES = 3'h7;
  localparam logic [1:0] HTRANS_NONSEQ    = 2'h2;
  localparam logic       HRESP_OKAY       = 1'b0;

  typedef enum logic {NVC_BUS_IDLE, NVC_BUS_PEND} nvc_bus_e;

  typedef struct packed {
    logic [CMD_W-1:0] code;
    logic             tgt_eeprom;
    logic             erase_eeprom;
    logic [15:0]      addr;
    logic [15:0]      data;
  } nvc_op_s;

endpackage

// File: nvc_array_model.sv
module nvc_array_model
  import nvc_pkg::*;
#(
  parameter int BUSY = 24
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        op_start,
  input  nvc_pkg::nvc_op_s op_req,
  output logic             flash_busy_in,
  output logic             eeprom_busy_in,
  output logic             write_fault_in,
  output logic             loc_update,
  output logic [15:0]      loc_update_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  int  cnt;
  wire page_op = op_req.code inside {CMD_PAGE_WRITE, CMD_PAGE_ERASE, CMD_ERASE_WR};
  wire takes   = op_start && cnt == 0 && op_req.code != CMD_BUF_CLEAR;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt             <= 0;
      flash_busy_in   <= 1'b0;
      eeprom_busy_in  <= 1'b0;
      write_fault_in  <= 1'b0;
      loc_update      <= 1'b0;
      loc_update_addr <= 16'h0000;
    end else begin
      loc_update     <= 1'b0;
      write_fault_in <= 1'b0;
      if (takes) begin
        cnt           <= BUSY;
        flash_busy_in <= (page_op && !op_req.tgt_eeprom) || op_req.code == CMD_CHIP_ERASE
                         || op_req.code == CMD_FUSE_WRITE;
        eeprom_busy_in <= (page_op && op_req.tgt_eeprom) || op_req.code == CMD_EE_ERASE
                          || (op_req.code == CMD_CHIP_ERASE && op_req.erase_eeprom);
      end else if (cnt == 1) begin
        cnt             <= 0;
        flash_busy_in   <= 1'b0;
        eeprom_busy_in  <= 1'b0;
        loc_update      <= 1'b1;
        loc_update_addr <= op_req.addr;
        // Odd page address stands in for a buffer filled from mixed sections
        write_fault_in  <= op_req.code == CMD_PAGE_WRITE && op_req.addr[0];
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// File: nvm_controller_regs_test.sv
module nvm_controller_regs_test
  import nvc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, rst_n = 0, hsel = 0, hwrite = 0, dbg_master = 0;
  logic        prot_key_open = 0, exec_in_boot = 0, keep_eeprom_on_erase = 0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic [31:0] seed = 32'd86370;
  logic        hreadyout, hresp, op_start, cpu_halt, boot_read_lock, app_write_protect, irq;
  logic        flash_busy_in, eeprom_busy_in, write_fault_in, loc_update;
  logic [15:0] loc_update_addr;
  logic [7:0]  shadow [6:9] = '{default: 8'h00};
  nvc_op_s     op_req, last_op;
  int          n_errors = 0, n_tests = 0, n_ops = 0, n_halt = 0, cyc = 0;

  nvc_controller u_nvc_controller (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dbg_master(dbg_master),
    .prot_key_open(prot_key_open), .exec_in_boot(exec_in_boot),
    .keep_eeprom_on_erase(keep_eeprom_on_erase), .flash_busy_in(flash_busy_in),
    .eeprom_busy_in(eeprom_busy_in), .write_fault_in(write_fault_in), .loc_update(loc_update),
    .loc_update_addr(loc_update_addr), .op_req(op_req), .op_start(op_start),
    .cpu_halt(cpu_halt), .boot_read_lock(boot_read_lock),
    .app_write_protect(app_write_protect), .irq(irq));
  nvc_array_model u_nvc_array_model (.clock(clock), .rst_n(rst_n), .op_start(op_start),
    .op_req(op_req), .flash_busy_in(flash_busy_in), .eeprom_busy_in(eeprom_busy_in),
    .write_fault_in(write_fault_in), .loc_update(loc_update),
    .loc_update_addr(loc_update_addr));

  initial forever #12.5 clock = ~clock;

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog sized well above the whole sequence; also counts launches and halt cycles
  // Sampled mid-cycle so the main sequence sees settled counts at the next rising edge
  always @(negedge clock) begin
    cyc++;
    if (op_start === 1'b1) begin
      n_ops++;
      last_op = op_req;
    end
    if (cpu_halt === 1'b1) n_halt++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] exp_state(logic [2:0] c, logic [15:0] a, logic k);
    logic tg;
    tg = a >= 16'h1400 && a <= 16'h14FF;
    if (c <= CMD_ERASE_WR) return tg ? 8'h02 : 8'h01;
    if (c == CMD_CHIP_ERASE) return k ? 8'h01 : 8'h03;
    return c == CMD_EE_ERASE ? 8'h02 : 8'h00;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= a;
    @(negedge clock);
    while (hreadyout !== 1'b1) @(negedge clock);
    @(posedge clock);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {PAD_ZERO, d};
    @(negedge clock);
    while (hreadyout !== 1'b1) @(negedge clock);
    @(posedge clock);
    rd = hrdata;
  endtask

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    xfer(1'b1, {26'h0, i, 2'h0}, d);
  endtask

  task automatic rdchk(input logic [3:0] i, input logic [7:0] e);
    xfer(1'b0, {26'h0, i, 2'h0}, 8'h00);
    chk(rd, {PAD_ZERO, e});
  endtask

  task automatic cmd(input logic [7:0] d, input logic key);
    prot_key_open <= key;
    wr(IDX_CMD, d);
    prot_key_open <= 1'b0;
  endtask

  task automatic setloc(input logic [15:0] a);
    wr(IDX_LOC_LO, a[7:0]);
    wr(IDX_LOC_HI, a[15:8]);
  endtask

  task automatic idle_wait;
    @(negedge clock);
    while ((flash_busy_in | eeprom_busy_in) !== 1'b0) @(negedge clock);
    repeat (10) @(posedge clock);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [15:0] a;
    int          n;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 10; i++) rdchk(4'(i), i == 4 ? 8'h01 : 8'h00);
    xfer(1'b0, 32'h0000_0040, 8'h00);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
    repeat (24) begin
      r = xs();
      shadow[6 + r[1:0]] = r[15:8];
      wr(4'h6 + {2'h0, r[1:0]}, r[15:8]);
    end
    for (int i = 6; i < 10; i++) rdchk(4'(i), shadow[i]);
    $display("test pairs done");
    cmd(8'h01, 1'b0);
    rdchk(IDX_CMD, 8'h00);
    cmd(8'hFF, 1'b1);
    rdchk(IDX_CMD, 8'h07);
    xfer(1'b0, 32'h0000_0040, 8'h00);
    chk(rd, 32'h0000_0000);
    chk(hresp, 32'h0000_0000);
    chk(n_ops, 0);
    $display("test protect done");
    for (int k = 0; k < 2; k++) begin
      for (int c = 1; c < 7; c++) begin
        r = xs();
        a = r[0] ? {8'h14, r[15:8]} : {1'b0, r[30:16]};
        keep_eeprom_on_erase <= k[0];
        setloc(a);
        n = n_halt;
        cmd({5'h00, 3'(c)}, 1'b1);
        chk(last_op.code, c);
        if (c < 4) chk(last_op.tgt_eeprom, a >= 16'h1400 && a <= 16'h14FF);
        if (c == 5) chk(last_op.erase_eeprom, !k[0]);
        rdchk(IDX_STATE, exp_state(3'(c), a, k[0]));
        if (c != 4) wr(IDX_LOC_LO, ~a[7:0]);
        idle_wait();
        if (c == 4) chk(n_halt - n, 7);
        rdchk(IDX_STATE, {5'h00, 1'(c == 1 && a[0]), 2'h0});
        rdchk(IDX_LOC_LO, a[7:0]);
      end
    end
    chk(n_ops, 12);
    $display("test commands done");
    r = xs();
    dbg_master <= 1'b1;
    setloc(r[15:0]);
    wr(IDX_DATA_LO, r[23:16]);
    wr(IDX_DATA_HI, r[31:24]);
    cmd(8'h07, 1'b0);
    dbg_master <= 1'b0;
    chk(last_op.code, CMD_FUSE_WRITE);
    chk({last_op.addr, last_op.data}, {r[15:0], r[31:16]});
    idle_wait();
    $display("test fuse done");
    cmd({5'h00, CMD_EE_ERASE}, 1'b1);
    wr(IDX_FLAGS, 8'hFF);
    rdchk(IDX_FLAGS, 8'h00);
    wr(IDX_IRQ_EN, 8'hFF);
    rdchk(IDX_IRQ_EN, 8'h01);
    chk(irq, 1'b0);
    idle_wait();
    rdchk(IDX_FLAGS, 8'h01);
    chk(irq, 1'b1);
    wr(IDX_IRQ_EN, 8'h00);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    $display("test irq done");
    wr(IDX_LOCK, 8'h02);
    rdchk(IDX_LOCK, 8'h00);
    wr(IDX_LOCK, 8'hFD);
    rdchk(IDX_LOCK, 8'h01);
    wr(IDX_LOCK, 8'h00);
    rdchk(IDX_LOCK, 8'h01);
    chk(app_write_protect, 1'b1);
    exec_in_boot <= 1'b1;
    wr(IDX_LOCK, 8'h02);
    rdchk(IDX_LOCK, 8'h03);
    chk(boot_read_lock, 1'b0);
    exec_in_boot <= 1'b0;
    repeat (3) @(posedge clock);
    chk(boot_read_lock, 1'b1);
    setloc(16'h9000);
    n = n_ops;
    cmd({5'h00, CMD_PAGE_WRITE}, 1'b1);
    repeat (3) @(posedge clock);
    chk(n_ops, n);
    rdchk(IDX_STATE, 8'h04);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdchk(IDX_LOCK, 8'h00);
    chk({boot_read_lock, app_write_protect}, 0);
    $display("test locks done");
    conclude();
  end
endmodule
